// [pspmc_pkg.sv]
/*
  Package for the pin state and power mode controller: device states,
  pin function codes, per-pin carriers and held state reset values.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package pspmc_pkg;
  // number of pins handled
  localparam int NPINS = 8;

  // device state codes, one-hot
  typedef enum logic [6:0] {
    PSPMC_ST_POR   = 7'h01,
    PSPMC_ST_XRST  = 7'h02,
    PSPMC_ST_IRST  = 7'h04,
    PSPMC_ST_RUN   = 7'h08,
    PSPMC_ST_TIMER = 7'h10,
    PSPMC_ST_LTIM  = 7'h20,
    PSPMC_ST_STOP  = 7'h40
  } pspmc_state_t;

  // selected pin function
  typedef enum logic [3:0] {
    PSPMC_FN_GPIO   = 4'h0,
    PSPMC_FN_JTAG   = 4'h1,
    PSPMC_FN_TRACE  = 4'h2,
    PSPMC_FN_EXTINT = 4'h3,
    PSPMC_FN_NMI    = 4'h4,
    PSPMC_FN_ANALOG = 4'h5,
    PSPMC_FN_MOSCO  = 4'h6,
    PSPMC_FN_SOSCO  = 4'h7,
    PSPMC_FN_OSCI   = 4'h8,
    PSPMC_FN_MODE   = 4'h9,
    PSPMC_FN_PERIPH = 4'hA
  } pspmc_func_t;

  // pad side of one pin
  typedef struct packed {
    logic oe;
    logic out;
    logic in_en;
    logic ana_en;
  } pspmc_pad_t;

  // functional side of one pin
  typedef struct packed {
    logic out;
    logic oe;
  } pspmc_drv_t;

  // reset values of held state
  localparam logic RST_HOLD_OE  = 1'b0;
  localparam logic RST_HOLD_OUT = 1'b0;
  localparam logic RST_CFG      = 1'b0;
endpackage
`default_nettype wire

// [pspmc_pin.sv]
/*
  One pin's state decision: driver enable, output, input gating, analog
  enable, and the held copy used in low power modes.
  Assumes state and level bit come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pspmc_pin
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire pspmc_pkg::pspmc_state_t st,
  input  wire logic                 standby_pin_level_bit,
  input  wire pspmc_pkg::pspmc_func_t  fn,
  input  wire pspmc_pkg::pspmc_drv_t   drv,
  input  wire logic                 periph_run,
  input  wire logic                 pad_in,
  output var  pspmc_pkg::pspmc_pad_t   pad,
  output var  logic                 core_in
);
  // ==========================================================
  // held copy
  logic hold_oe_r;
  logic hold_out_r;
  logic running;
  assign running = (st == pspmc_pkg::PSPMC_ST_RUN);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_oe_r  <= pspmc_pkg::RST_HOLD_OE;
      hold_out_r <= pspmc_pkg::RST_HOLD_OUT;
    end
    else if (running)
    begin
      hold_oe_r  <= drv.oe;
      hold_out_r <= drv.out;
    end
  end

  // ==========================================================
  // decision
  logic is_rst;
  logic is_por;
  logic is_sby;
  logic is_gp;
  logic wake;
  assign is_por = (st == pspmc_pkg::PSPMC_ST_POR);
  assign is_rst = (st == pspmc_pkg::PSPMC_ST_XRST) ||
                  (st == pspmc_pkg::PSPMC_ST_IRST);
  assign is_sby = (st == pspmc_pkg::PSPMC_ST_TIMER) ||
                  (st == pspmc_pkg::PSPMC_ST_LTIM) ||
                  (st == pspmc_pkg::PSPMC_ST_STOP);
  assign wake   = (fn == pspmc_pkg::PSPMC_FN_EXTINT) ||
                  (fn == pspmc_pkg::PSPMC_FN_NMI);
  assign is_gp  = (fn == pspmc_pkg::PSPMC_FN_GPIO) ||
                  (fn == pspmc_pkg::PSPMC_FN_PERIPH);

  // held output: a running peripheral keeps driving, a port or PERIPH pin keeps value
  logic h_oe;
  logic h_out;
  assign h_oe  = (periph_run && !is_gp) ? drv.oe  : hold_oe_r;
  assign h_out = (periph_run && !is_gp) ? drv.out : hold_out_r;

  // osc output stop conditions
  logic mosc_stop;
  logic sosc_stop;
  assign mosc_stop = (st == pspmc_pkg::PSPMC_ST_LTIM) ||
                     (st == pspmc_pkg::PSPMC_ST_STOP);
  assign sosc_stop = (st == pspmc_pkg::PSPMC_ST_STOP);

  logic iso;
  // jtag pins keep their state in standby whatever the level bit says
  assign iso = is_sby && standby_pin_level_bit && !wake &&
               (fn != pspmc_pkg::PSPMC_FN_JTAG);

  logic oe_c;
  logic out_c;
  logic ien_c;
  logic ana_c;
  always_comb
  begin
    oe_c  = h_oe;
    out_c = h_out;
    ien_c = 1'b1;
    ana_c = 1'b0;
    if (fn == pspmc_pkg::PSPMC_FN_ANALOG)
    begin
      oe_c  = 1'b0;
      ien_c = 1'b0;
      ana_c = 1'b1;
    end
    else if (fn == pspmc_pkg::PSPMC_FN_OSCI ||
             fn == pspmc_pkg::PSPMC_FN_MODE)
    begin
      oe_c  = 1'b0;
    end
    else if (fn == pspmc_pkg::PSPMC_FN_MOSCO ||
             fn == pspmc_pkg::PSPMC_FN_SOSCO)
    begin
      if (is_por || is_rst ||
          (fn == pspmc_pkg::PSPMC_FN_MOSCO ? mosc_stop : sosc_stop))
      begin
        oe_c  = 1'b0;
        ien_c = 1'b0;
      end
      else
      begin
        ien_c = 1'b0;
      end
    end
    else if (is_por)
    begin
      oe_c  = 1'b0;
      ien_c = 1'b0;
    end
    else if (is_rst)
    begin
      oe_c  = (fn == pspmc_pkg::PSPMC_FN_JTAG) ? 1'b0 : 1'b0;
      ien_c = 1'b1;
    end
    else if (fn == pspmc_pkg::PSPMC_FN_TRACE && is_sby)
    begin
      oe_c  = drv.oe;
      out_c = drv.out;
    end
    else if (iso)
    begin
      oe_c  = 1'b0;
      ien_c = 1'b0;
    end
    else if (!running)
    begin
      oe_c  = h_oe;
    end
    else
    begin
      oe_c  = drv.oe;
      out_c = drv.out;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pad     <= '0;
      core_in <= 1'b0;
    end
    else
    begin
      pad.oe     <= oe_c;
      pad.out    <= oe_c ? out_c : 1'b0;
      pad.in_en  <= ien_c;
      pad.ana_en <= ana_c;
      core_in    <= ien_c ? pad_in : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [pspmc_top.sv]
/*
  Pin state and power mode controller: derives the device state from
  reset sources and power mode, locks pin configuration during resets,
  and instantiates one pin decision per pin.
  Assumes pad inputs and the external reset pin are asynchronous; mode
  and configuration inputs come from logic on CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
module pspmc_top
(
  input  wire logic                                   CLOCK,
  input  wire logic                                   RST,
  input  wire logic                                   POR_ACTIVE,
  input  wire logic                                   EXTERNAL_RESET_N_PIN,
  input  wire logic                                   INT_RESET,
  input  wire logic [1:0]                             PWR_MODE,
  input  wire logic                                   STANDBY_PIN_LEVEL_BIT,
  input  wire logic                                   CFG_WE,
  input  wire logic [4*pspmc_pkg::NPINS-1:0]          CFG_FUNC,
  input  wire pspmc_pkg::pspmc_drv_t [pspmc_pkg::NPINS-1:0] DRV,
  input  wire logic [pspmc_pkg::NPINS-1:0]            PERIPH_RUN,
  input  wire logic [pspmc_pkg::NPINS-1:0]            PAD_IN,
  output var  pspmc_pkg::pspmc_pad_t [pspmc_pkg::NPINS-1:0] PAD,
  output var  logic [pspmc_pkg::NPINS-1:0]            CORE_IN,
  output var  pspmc_pkg::pspmc_state_t                STATE
);
  // ==========================================================
  // synchronisers
  logic [2:0] xr_sync_r;
  logic       xr_low_r;
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      // start at the pin's idle high level so no false reset follows RST
      xr_sync_r <= 3'h7;
      xr_low_r  <= 1'b0;
    end
    else
    begin
      xr_sync_r <= {xr_sync_r[1:0], EXTERNAL_RESET_N_PIN};
      if (xr_sync_r[1] == xr_sync_r[2])
        xr_low_r <= !xr_sync_r[2];
    end
  end

  logic [pspmc_pkg::NPINS-1:0] ps1_r;
  logic [pspmc_pkg::NPINS-1:0] ps2_r;
  logic [pspmc_pkg::NPINS-1:0] ps3_r;
  logic [pspmc_pkg::NPINS-1:0] pin_r;
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      ps1_r <= '0;
      ps2_r <= '0;
      ps3_r <= '0;
      pin_r <= '0;
    end
    else
    begin
      ps1_r <= PAD_IN;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
      pin_r <= (ps2_r & ps3_r) | (pin_r & (ps2_r | ps3_r));
    end
  end

  // ==========================================================
  // device state, priority por > pin reset > internal reset > mode
  pspmc_pkg::pspmc_state_t st_nxt;
  pspmc_pkg::pspmc_state_t st_mode;
  assign st_mode = (PWR_MODE == 2'h0) ? pspmc_pkg::PSPMC_ST_RUN :
                   (PWR_MODE == 2'h1) ? pspmc_pkg::PSPMC_ST_TIMER :
                   (PWR_MODE == 2'h2) ? pspmc_pkg::PSPMC_ST_LTIM :
                                        pspmc_pkg::PSPMC_ST_STOP;
  assign st_nxt = POR_ACTIVE ? pspmc_pkg::PSPMC_ST_POR :
                  xr_low_r   ? pspmc_pkg::PSPMC_ST_XRST :
                  INT_RESET  ? pspmc_pkg::PSPMC_ST_IRST : st_mode;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
      STATE <= pspmc_pkg::PSPMC_ST_POR;
    else
      STATE <= st_nxt;
  end

  // ==========================================================
  // configuration, locked during any reset state
  logic cfg_lock;
  logic [4*pspmc_pkg::NPINS-1:0] func_r;
  assign cfg_lock = (STATE == pspmc_pkg::PSPMC_ST_POR) ||
                    (STATE == pspmc_pkg::PSPMC_ST_XRST) ||
                    (STATE == pspmc_pkg::PSPMC_ST_IRST);
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      func_r <= '0;
    else if (CFG_WE && !cfg_lock)
      func_r <= CFG_FUNC;
  end

  // ==========================================================
  // pins
  genvar gi;
  generate
    for (gi = 0; gi < pspmc_pkg::NPINS; gi++)
    begin : g_pin
      pspmc_pin u_pin
      (
        .clk        (CLOCK),
        .rst        (RST),
        .st         (STATE),
        .standby_pin_level_bit        (STANDBY_PIN_LEVEL_BIT),
        .fn         (pspmc_pkg::pspmc_func_t'(func_r[4*gi +: 4])),
        .drv        (DRV[gi]),
        .periph_run (PERIPH_RUN[gi]),
        .pad_in     (pin_r[gi]),
        .pad        (PAD[gi]),
        .core_in    (CORE_IN[gi])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// [pspmc_properties.sv]
/* Checker for the pin controller, bound to its top module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module pspmc_properties
(
  input wire logic                                    CLOCK,
  input wire logic                                    RST,
  input wire logic                                    POR_ACTIVE,
  input wire logic                                    EXTERNAL_RESET_N_PIN,
  input wire logic                                    INT_RESET,
  input wire logic [1:0]                              PWR_MODE,
  input wire pspmc_pkg::pspmc_pad_t [pspmc_pkg::NPINS-1:0] PAD,
  input wire logic [pspmc_pkg::NPINS-1:0]             CORE_IN,
  input wire pspmc_pkg::pspmc_state_t                 STATE
);
  logic [pspmc_pkg::NPINS-1:0] oe_v;
  logic [pspmc_pkg::NPINS-1:0] ie_v;
  logic [pspmc_pkg::NPINS-1:0] ae_v;
  wire                         quiet = EXTERNAL_RESET_N_PIN && !POR_ACTIVE;
  always_comb
    for (int i = 0; i < pspmc_pkg::NPINS; i++)
    begin
      oe_v[i] = PAD[i].oe;
      ie_v[i] = PAD[i].in_en;
      ae_v[i] = PAD[i].ana_en;
    end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================
  // assertions
  por_state_a: assert property (POR_ACTIVE |=> STATE == pspmc_pkg::PSPMC_ST_POR)
    else $error("power-on reset state not entered");
  por_hiz_a: assert property (STATE == pspmc_pkg::PSPMC_ST_POR |=> oe_v == 8'h00)
    else $error("pin driven during power-on reset");
  in_gate_a: assert property ((CORE_IN & ~ie_v) == 8'h00)
    else $error("disabled input not forced low");
  analog_off_a: assert property ((ae_v & (oe_v | CORE_IN)) == 8'h00)
    else $error("analog pin drives or reads digital");
  ext_rst_a: assert property ((!EXTERNAL_RESET_N_PIN && !POR_ACTIVE) [*6]
    |-> STATE == pspmc_pkg::PSPMC_ST_XRST)
    else $error("low reset pin not seen as reset");
  ext_rel_a: assert property ((quiet && !INT_RESET) [*6]
    |-> STATE != pspmc_pkg::PSPMC_ST_XRST)
    else $error("high reset pin still seen as reset");
  int_rst_a: assert property ((quiet && INT_RESET) [*6]
    |-> STATE == pspmc_pkg::PSPMC_ST_IRST)
    else $error("internal reset state not entered");
  stop_map_a: assert property ((quiet && !INT_RESET && PWR_MODE == 2'h3) [*6]
    |-> STATE == pspmc_pkg::PSPMC_ST_STOP)
    else $error("stop state not entered");
  run_map_a: assert property ((quiet && !INT_RESET && PWR_MODE == 2'h0) [*6]
    |-> STATE == pspmc_pkg::PSPMC_ST_RUN)
    else $error("run state not entered");
  cover property (STATE == pspmc_pkg::PSPMC_ST_STOP);
  cover property (STATE == pspmc_pkg::PSPMC_ST_XRST);
  cover property (ae_v != 8'h00);
endmodule
bind pspmc_top pspmc_properties u_prop
(
  .CLOCK(CLOCK), .RST(RST), .POR_ACTIVE(POR_ACTIVE),
  .EXTERNAL_RESET_N_PIN(EXTERNAL_RESET_N_PIN), .INT_RESET(INT_RESET),
  .PWR_MODE(PWR_MODE), .PAD(PAD), .CORE_IN(CORE_IN), .STATE(STATE)
);
`default_nettype wire

// [pspmc_board.sv]
/* Board model: a driven pad reads back its own level, an undriven pad
   floats, shown as a level that flips every cycle.
   Assumes one pad record per pin and no pull resistors. */
`timescale 1ns/1ps
`default_nettype none
module pspmc_board
(
  input  wire logic                                    clk,
  input  wire pspmc_pkg::pspmc_pad_t [pspmc_pkg::NPINS-1:0] pad,
  output logic [pspmc_pkg::NPINS-1:0]                  pad_in
);
  logic flip_r = 1'b0;
  always @(posedge clk)
    flip_r <= ~flip_r;
  always_comb
    for (int i = 0; i < pspmc_pkg::NPINS; i++)
      pad_in[i] = pad[i].oe ? pad[i].out : flip_r;
endmodule
`default_nettype wire

// [pin_state_power_mode_control_tb_top.sv]
/* Testbench: scenario tasks for the pin controller with a board model.
   Assumes the package, checker and board model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pin_state_power_mode_control_tb_top;
  localparam int          N   = pspmc_pkg::NPINS;
  localparam logic [31:0] CFG = 32'h9765_4320;
  localparam logic [31:0] CFG2 = 32'h9765_4A81;
  logic                          clk      = 1'b0;
  logic                          rst      = 1'b1;
  logic                          por      = 1'b0;
  logic                          xrst_n   = 1'b1;
  logic                          irst     = 1'b0;
  logic [1:0]                    pmode    = 2'h0;
  logic                          standby_pin_level_bit      = 1'b0;
  logic                          cfg_we   = 1'b0;
  logic [31:0]                   cfg_func = 32'h0000_0000;
  pspmc_pkg::pspmc_drv_t [N-1:0] drv      = 16'h0000;
  logic [N-1:0]                  prun     = 8'hFF;
  logic [N-1:0]                  pad_in;
  pspmc_pkg::pspmc_pad_t [N-1:0] pad;
  logic [N-1:0]                  core_in, oe, ie, ae, ou;
  pspmc_pkg::pspmc_state_t       state;
  int                            num_errors = 0;
  int                            compares   = 0;
  always #12.5 clk = ~clk;
  always_comb
    for (int i = 0; i < N; i++)
    begin
      oe[i] = pad[i].oe;
      ie[i] = pad[i].in_en;
      ae[i] = pad[i].ana_en;
      ou[i] = pad[i].out;
    end
  pspmc_top dut
  (
    .CLOCK(clk), .RST(rst), .POR_ACTIVE(por), .EXTERNAL_RESET_N_PIN(xrst_n),
    .INT_RESET(irst), .PWR_MODE(pmode), .STANDBY_PIN_LEVEL_BIT(standby_pin_level_bit),
    .CFG_WE(cfg_we), .CFG_FUNC(cfg_func), .DRV(drv), .PERIPH_RUN(prun),
    .PAD_IN(pad_in), .PAD(pad), .CORE_IN(core_in), .STATE(state)
  );
  pspmc_board u_board (.clk(clk), .pad(pad), .pad_in(pad_in));
  // ==========================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wcfg(input logic [31:0] v);
    @(posedge clk);
    cfg_func <= v;
    cfg_we   <= 1'b1;
    @(posedge clk);
    cfg_we   <= 1'b0;
  endtask
  task automatic sdrv(input logic [7:0] v);
    @(posedge clk);
    for (int i = 0; i < N; i++)
      drv[i] <= {v[i], 1'b1};
  endtask
  task automatic go(input logic [1:0] m, input logic s, input logic x,
                    input logic r);
    @(posedge clk);
    pmode  <= m;
    standby_pin_level_bit    <= s;
    xrst_n <= x;
    irst   <= r;
    cyc(8);
  endtask
  task automatic results;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_lock;
    @(posedge clk);
    por <= 1'b1;
    cyc(3);
    chk({1'b0, state}, {1'b0, pspmc_pkg::PSPMC_ST_POR});
    wcfg(32'h5555_5555);
    @(posedge clk);
    por <= 1'b0;
    cyc(4);
    chk(ae, 8'h00);
    wcfg(CFG);
    cyc(3);
    chk(ae, 8'h10);
  endtask
  task automatic t_run;
    sdrv(8'hA5);
    cyc(6);
    chk(oe, 8'h6F);
    chk(core_in & 8'h11, 8'h01);
  endtask
  task automatic t_hold;
    go(2'h1, 1'b0, 1'b1, 1'b0);
    sdrv(8'h5A);
    cyc(3);
    chk(ou & 8'h07, 8'h03);
    chk(oe & 8'h61, 8'h61);
    @(posedge clk);
    prun <= 8'hFB;
    cyc(3);
    chk(ou & 8'h04, 8'h04);
    @(posedge clk);
    prun <= 8'hFF;
    go(2'h2, 1'b0, 1'b1, 1'b0);
    chk(oe & 8'h60, 8'h40);
    go(2'h3, 1'b0, 1'b1, 1'b0);
    chk(oe & 8'h60, 8'h00);
  endtask
  task automatic t_iso;
    go(2'h3, 1'b1, 1'b1, 1'b0);
    chk(oe & 8'h0F, 8'h0E);
    chk(core_in & 8'h01, 8'h00);
    chk(ie & 8'h80, 8'h80);
  endtask
  task automatic t_rst;
    go(2'h0, 1'b0, 1'b0, 1'b0);
    chk({1'b0, state}, {1'b0, pspmc_pkg::PSPMC_ST_XRST});
    chk(ie & 8'h01, 8'h01);
    go(2'h0, 1'b0, 1'b1, 1'b1);
    chk({1'b0, state}, {1'b0, pspmc_pkg::PSPMC_ST_IRST});
    chk(oe & 8'h01, 8'h00);
    go(2'h0, 1'b0, 1'b1, 1'b0);
    chk({1'b0, state}, {1'b0, pspmc_pkg::PSPMC_ST_RUN});
  endtask
  task automatic t_alt;
    wcfg(CFG2);
    cyc(3);
    chk(oe & 8'h07, 8'h05);
    chk(ie & 8'h02, 8'h02);
    go(2'h3, 1'b1, 1'b1, 1'b0);
    chk(oe & 8'h07, 8'h01);
    chk(ie & 8'h06, 8'h02);
    go(2'h0, 1'b0, 1'b0, 1'b0);
    chk(oe & 8'h07, 8'h00);
    chk(ie & 8'h07, 8'h07);
    go(2'h0, 1'b0, 1'b1, 1'b0);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_lock();
    t_run();
    t_hold();
    t_iso();
    t_rst();
    t_alt();
    results();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
